//--- snzcg_pkg.sv
// package: constants and types for the snooze clock gating block
`default_nettype none
package snzcg_pkg;
   // ======================================================
   // power states
   typedef enum logic [1:0] {
      SNZ_RUN,
      SNZ_STOP,
      SNZ_SNOOZE
   } snzcg_state_t;

   // ======================================================
   // option byte field positions
   localparam int unsigned OPT_WIDTH         = 8;
   localparam int unsigned OPT_WDT_STBY_BIT  = 0;
   localparam int unsigned OPT_WDT_EN_BIT    = 4;

   // ======================================================
   // comparator channels
   localparam int unsigned CMP_NUM           = 6;
   localparam logic [CMP_NUM-1:0] CMP_SNOOZE_MASK = 6'h05;

   // ======================================================
   // values after reset
   localparam logic SNZ_RST_CPU_CLK   = 1'b1;
   localparam logic SNZ_RST_HOCO      = 1'b1;
   localparam logic SNZ_RST_SUBCLK    = 1'b0;
   localparam logic SNZ_RST_LOCO      = 1'b0;
   localparam logic SNZ_RST_PERIPH    = 1'b1;
endpackage : snzcg_pkg
`default_nettype wire

//--- snzcg_cmp_if.sv
// interface: comparator gating signals between controller and gate
`default_nettype none
interface snzcg_cmp_if #(parameter int unsigned N = 6);
   logic [N-1:0] stop_rel_en;
   logic [N-1:0] filter_en;
   logic [N-1:0] run_req;
   logic         low_power;
   logic         snooze;
   logic [N-1:0] en;
   modport gate (input stop_rel_en, filter_en, run_req, low_power, snooze,
                 output en);
   modport ctrl (output stop_rel_en, filter_en, run_req, low_power, snooze,
                 input en);
endinterface : snzcg_cmp_if
`default_nettype wire

//--- snzcg_cmp_gate.sv
// module: per-channel comparator enable gate for low-power states
`default_nettype none
module snzcg_cmp_gate
   import snzcg_pkg::*;
#(
   parameter logic [CMP_NUM-1:0] SNOOZE_MASK = CMP_SNOOZE_MASK
)(
   snzcg_cmp_if.gate cmp
);
   // ======================================================
   // gating
   // a channel with its filter on cannot run without the cpu clock, so
   // it is dropped in stop and snooze even if release is enabled
   always_comb begin
      for (int i = 0; i < CMP_NUM; i++) begin
         if (!cmp.low_power) begin
            cmp.en[i] = cmp.run_req[i];
         end else if (cmp.snooze) begin
            cmp.en[i] = cmp.run_req[i] & SNOOZE_MASK[i]
                        & cmp.stop_rel_en[i] & ~cmp.filter_en[i];
         end else begin
            cmp.en[i] = cmp.run_req[i] & SNOOZE_MASK[i]
                        & cmp.stop_rel_en[i] & ~cmp.filter_en[i];
         end
      end
   end
endmodule : snzcg_cmp_gate
`default_nettype wire

//--- snzcg_ctrl.sv
// module: snooze state controller with clock and peripheral gating
// ======================================================
`default_nettype none
module snzcg_ctrl
   import snzcg_pkg::*;
(
   input  wire logic                 CLK_IN,
   input  wire logic                 RSTN_IN,
   input  wire logic                 STOP_REQ_IN,
   input  wire logic                 WAKE_IN,
   input  wire logic                 SNOOZE_DONE_IN,
   input  wire logic                 CPU_ON_HOCO_IN,
   input  wire logic                 SERIAL_RX_EVENT_IN,
   input  wire logic                 AD_TIMER_TRIG_IN,
   input  wire logic [OPT_WIDTH-1:0] OPTION_BYTE_IN,
   input  wire logic                 IT_LOWSPEED_CLOCK_SELECT_IN,
   input  wire logic                 SUB_XT_REQ_IN,
   input  wire logic                 SUB_EXS_REQ_IN,
   input  wire logic [CMP_NUM-1:0]   CMP_STOP_RELEASE_ENABLE_IN,
   input  wire logic [CMP_NUM-1:0]   CMP_FILTER_EN_IN,
   input  wire logic [CMP_NUM-1:0]   CMP_RUN_REQ_IN,
   output var  logic [1:0]           STATE_OUT,
   output var  logic                 CPU_CLK_EN_OUT,
   output var  logic                 MEM_EN_OUT,
   output var  logic                 HOCO_EN_OUT,
   output var  logic                 XTAL_MAIN_EN_OUT,
   output var  logic                 EXT_MAIN_EN_OUT,
   output var  logic                 SUB_XT_EN_OUT,
   output var  logic                 SUB_EXS_EN_OUT,
   output var  logic                 LOCO_EN_OUT,
   output var  logic                 PORT_LATCH_HOLD_OUT,
   output var  logic [CMP_NUM-1:0]   CMP_EN_OUT,
   output var  logic                 TAU_EN_OUT,
   output var  logic                 GP_TIMER_EN_OUT,
   output var  logic                 RTC_EN_OUT,
   output var  logic                 ITMR_EN_OUT,
   output var  logic                 ADC_EN_OUT,
   output var  logic                 PGA_EN_OUT
);
   // ======================================================
   // state
   snzcg_state_t state_q;
   snzcg_state_t state_d;
   logic         hoco_src_q;
   logic         wake_evt;
   logic         lp_d;
   logic         sn_d;
   logic         loco_run;

   snzcg_cmp_if #(.N(CMP_NUM)) cmp_bus ();

   assign wake_evt = SERIAL_RX_EVENT_IN | AD_TIMER_TRIG_IN;
   assign lp_d     = (state_d != SNZ_RUN);
   assign sn_d     = (state_d == SNZ_SNOOZE);

   // ======================================================
   // next state
   // a cpu wake beats a snooze trigger in the same cycle, since the
   // interrupt makes the snooze pointless
   always_comb begin
      state_d = state_q;
      case (state_q)
         SNZ_RUN: begin
            if (STOP_REQ_IN) begin
               state_d = SNZ_STOP;
            end
         end
         SNZ_STOP: begin
            if (WAKE_IN) begin
               state_d = SNZ_RUN;
            end else if (wake_evt && hoco_src_q) begin
               state_d = SNZ_SNOOZE;
            end
         end
         SNZ_SNOOZE: begin
            if (WAKE_IN) begin
               state_d = SNZ_RUN;
            end else if (SNOOZE_DONE_IN) begin
               state_d = SNZ_STOP;
            end
         end
         default: begin
            state_d = SNZ_RUN;
         end
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         state_q <= SNZ_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // clock source of the cpu is noted when stop is entered
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         hoco_src_q <= 1'b1;
      end else if (state_q == SNZ_RUN && STOP_REQ_IN) begin
         hoco_src_q <= CPU_ON_HOCO_IN;
      end
   end

   // ======================================================
   // cpu, memory and main clocks
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         STATE_OUT        <= 2'h0;
         CPU_CLK_EN_OUT   <= SNZ_RST_CPU_CLK;
         MEM_EN_OUT       <= SNZ_RST_CPU_CLK;
         HOCO_EN_OUT      <= SNZ_RST_HOCO;
         XTAL_MAIN_EN_OUT <= 1'b0;
         EXT_MAIN_EN_OUT  <= 1'b0;
      end else begin
         STATE_OUT        <= state_d;
         CPU_CLK_EN_OUT   <= !lp_d;
         MEM_EN_OUT       <= !lp_d;
         HOCO_EN_OUT      <= (!lp_d && CPU_ON_HOCO_IN) || sn_d;
         XTAL_MAIN_EN_OUT <= !lp_d && !CPU_ON_HOCO_IN;
         EXT_MAIN_EN_OUT  <= 1'b0;
      end
   end

   // ======================================================
   // subsystem clocks and port latches
   // requests are only followed in run; stop and snooze freeze them
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         SUB_XT_EN_OUT       <= SNZ_RST_SUBCLK;
         SUB_EXS_EN_OUT      <= SNZ_RST_SUBCLK;
         PORT_LATCH_HOLD_OUT <= 1'b0;
      end else begin
         if (!lp_d) begin
            SUB_XT_EN_OUT  <= SUB_XT_REQ_IN;
            SUB_EXS_EN_OUT <= SUB_EXS_REQ_IN;
         end
         PORT_LATCH_HOLD_OUT <= lp_d;
      end
   end

   // ======================================================
   // low-speed oscillator
   assign loco_run = IT_LOWSPEED_CLOCK_SELECT_IN
                     || (OPTION_BYTE_IN[OPT_WDT_EN_BIT]
                         && OPTION_BYTE_IN[OPT_WDT_STBY_BIT]);

   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         LOCO_EN_OUT <= SNZ_RST_LOCO;
      end else if (lp_d) begin
         LOCO_EN_OUT <= loco_run;
      end else begin
         LOCO_EN_OUT <= IT_LOWSPEED_CLOCK_SELECT_IN
                        || OPTION_BYTE_IN[OPT_WDT_EN_BIT];
      end
   end

   // ======================================================
   // comparators
   assign cmp_bus.stop_rel_en = CMP_STOP_RELEASE_ENABLE_IN;
   assign cmp_bus.filter_en   = CMP_FILTER_EN_IN;
   assign cmp_bus.run_req     = CMP_RUN_REQ_IN;
   assign cmp_bus.low_power   = lp_d;
   assign cmp_bus.snooze      = sn_d;

   snzcg_cmp_gate #(.SNOOZE_MASK(CMP_SNOOZE_MASK)) u_cmp_gate (
      .cmp (cmp_bus)
   );

   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         CMP_EN_OUT <= '0;
      end else begin
         CMP_EN_OUT <= cmp_bus.en;
      end
   end

   // ======================================================
   // peripheral enables
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         TAU_EN_OUT      <= SNZ_RST_PERIPH;
         GP_TIMER_EN_OUT <= SNZ_RST_PERIPH;
         RTC_EN_OUT      <= SNZ_RST_PERIPH;
         ITMR_EN_OUT     <= SNZ_RST_PERIPH;
         ADC_EN_OUT      <= SNZ_RST_PERIPH;
         PGA_EN_OUT      <= SNZ_RST_PERIPH;
      end else begin
         TAU_EN_OUT      <= !lp_d;
         GP_TIMER_EN_OUT <= !lp_d;
         RTC_EN_OUT      <= 1'b1;
         ITMR_EN_OUT     <= 1'b1;
         ADC_EN_OUT      <= !lp_d || sn_d;
         PGA_EN_OUT      <= 1'b1;
      end
   end

   // ======================================================
   // assertions
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   AST_SNOOZE_ENTRY: assert property (
      (state_q == SNZ_STOP && wake_evt && hoco_src_q && !WAKE_IN)
      |=> (state_q == SNZ_SNOOZE) && (STATE_OUT == 2'(SNZ_SNOOZE)))
      else $error("snooze not entered after wake event in stop");

   AST_CPU_GATED: assert property (
      (state_q == SNZ_SNOOZE) |-> (!CPU_CLK_EN_OUT && !MEM_EN_OUT))
      else $error("cpu clock or memory enabled in snooze");

   AST_HOCO_START: assert property (
      (state_q == SNZ_STOP ##1 state_q == SNZ_SNOOZE)
      |-> (HOCO_EN_OUT && !XTAL_MAIN_EN_OUT && !EXT_MAIN_EN_OUT))
      else $error("wrong main clocks on snooze entry");

   AST_SUBCLK_HELD: assert property (
      (state_q == SNZ_SNOOZE && $past(state_q) != SNZ_RUN)
      |-> ($stable(SUB_XT_EN_OUT) && $stable(SUB_EXS_EN_OUT)
           && PORT_LATCH_HOLD_OUT))
      else $error("subsystem clock or port latch changed in snooze");

   AST_LOCO_SEL: assert property (
      (state_q == SNZ_SNOOZE)
      |-> (LOCO_EN_OUT == ($past(IT_LOWSPEED_CLOCK_SELECT_IN)
          || ($past(OPTION_BYTE_IN[OPT_WDT_EN_BIT])
              && $past(OPTION_BYTE_IN[OPT_WDT_STBY_BIT])))))
      else $error("low-speed oscillator enable wrong in snooze");

   AST_CMP_CHANNELS: assert property (
      (state_q == SNZ_SNOOZE) |-> ((CMP_EN_OUT & ~CMP_SNOOZE_MASK) == '0))
      else $error("comparator outside a and c enabled in snooze");

   AST_CMP_COND: assert property (
      (state_q == SNZ_SNOOZE)
      |-> ((CMP_EN_OUT & ~($past(CMP_STOP_RELEASE_ENABLE_IN)
                           & ~$past(CMP_FILTER_EN_IN))) == '0))
      else $error("comparator running without release or with filter");

   AST_PERIPH: assert property (
      (state_q == SNZ_SNOOZE)
      |-> (!TAU_EN_OUT && !GP_TIMER_EN_OUT && RTC_EN_OUT && ITMR_EN_OUT
           && ADC_EN_OUT && PGA_EN_OUT))
      else $error("peripheral enables wrong in snooze");

   COV_SNOOZE_ENTRY: cover property (
      state_q == SNZ_STOP ##1 state_q == SNZ_SNOOZE);
   COV_SNOOZE_BACK_TO_STOP: cover property (
      state_q == SNZ_SNOOZE ##1 state_q == SNZ_STOP);
   COV_SNOOZE_WAKE: cover property (
      state_q == SNZ_SNOOZE ##1 state_q == SNZ_RUN);
   COV_CMP_IN_SNOOZE: cover property (
      state_q == SNZ_SNOOZE && CMP_EN_OUT[0]);
endmodule : snzcg_ctrl
`default_nettype wire

//--- snzcg_wake_src.sv
// model: on-chip peripherals raising wakeup events toward the controller
`default_nettype none
module snzcg_wake_src (
   input  wire logic clk_in,
   input  wire logic fire_rx_in,
   input  wire logic fire_ad_in,
   output var  logic rx_event_out,
   output var  logic ad_trig_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================
   // events are the fire inputs registered one cycle later; a held fire input gives a held level
   always_ff @(posedge clk_in) begin
      rx_event_out <= fire_rx_in;
      ad_trig_out  <= fire_ad_in;
   end
endmodule // snzcg_wake_src
`default_nettype wire

//--- snooze_mode_clock_gating_bench.sv
// bench: self-checking test of the snooze clock gating controller
`default_nettype none
module snooze_mode_clock_gating_bench
   import snzcg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic it; logic [7:0] opt; logic [5:0] rel, filt, run;
      logic loco; logic [5:0] cmp;
   } snzcg_row_t;
   // ======================================================
   // stimulus and observed signals
   logic clk, rstn, stop_req, wake, done, on_hoco, it_sel, xt_req, exs_req;
   logic fire_rx, fire_ad, rx_ev, ad_trig;
   logic [OPT_WIDTH-1:0] opt;
   logic [CMP_NUM-1:0]   rel, filt, run, cmp;
   logic [1:0]           st;
   logic cpu, mem, hoco, xtal, ext, sxt, sexs, loco, hold;
   logic tau, gp, rtc, itmr, adc, pga;
   int err_count, num_checks;
   snzcg_row_t r;
   snzcg_row_t rows [5] = '{
      '{1'h1, 8'h00, 6'h3f, 6'h00, 6'h3f, 1'h1, 6'h05},
      '{1'h0, 8'h00, 6'h3f, 6'h01, 6'h3f, 1'h0, 6'h04},
      '{1'h0, 8'h10, 6'h3e, 6'h00, 6'h3f, 1'h0, 6'h04},
      '{1'h0, 8'h11, 6'h3f, 6'h00, 6'h3b, 1'h1, 6'h01},
      '{1'h0, 8'h01, 6'h3f, 6'h3a, 6'h3f, 1'h0, 6'h05}};

   snzcg_wake_src i_snzcg_wake_src (.clk_in(clk), .fire_rx_in(fire_rx),
      .fire_ad_in(fire_ad), .rx_event_out(rx_ev), .ad_trig_out(ad_trig));
   snzcg_ctrl i_snzcg_ctrl (.CLK_IN(clk), .RSTN_IN(rstn),
      .STOP_REQ_IN(stop_req), .WAKE_IN(wake), .SNOOZE_DONE_IN(done),
      .CPU_ON_HOCO_IN(on_hoco), .SERIAL_RX_EVENT_IN(rx_ev),
      .AD_TIMER_TRIG_IN(ad_trig), .OPTION_BYTE_IN(opt),
      .IT_LOWSPEED_CLOCK_SELECT_IN(it_sel), .SUB_XT_REQ_IN(xt_req),
      .SUB_EXS_REQ_IN(exs_req), .CMP_STOP_RELEASE_ENABLE_IN(rel),
      .CMP_FILTER_EN_IN(filt), .CMP_RUN_REQ_IN(run), .STATE_OUT(st),
      .CPU_CLK_EN_OUT(cpu), .MEM_EN_OUT(mem), .HOCO_EN_OUT(hoco),
      .XTAL_MAIN_EN_OUT(xtal), .EXT_MAIN_EN_OUT(ext), .SUB_XT_EN_OUT(sxt),
      .SUB_EXS_EN_OUT(sexs), .LOCO_EN_OUT(loco),
      .PORT_LATCH_HOLD_OUT(hold), .CMP_EN_OUT(cmp), .TAU_EN_OUT(tau),
      .GP_TIMER_EN_OUT(gp), .RTC_EN_OUT(rtc), .ITMR_EN_OUT(itmr),
      .ADC_EN_OUT(adc), .PGA_EN_OUT(pga));

   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // ======================================================
   // compare tasks
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk_bit(string n, logic e, logic g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_st(snzcg_state_t e);
      num_checks++;
      if (st !== 2'(e)) begin
         err_count++;
         $display("wrong value state exp %h got %h", 2'(e), st);
      end
   endtask
   task automatic chk_cmp(logic [5:0] e);
      num_checks++;
      if (cmp !== e) begin
         err_count++;
         $display("wrong value cmp_en exp %h got %h", e, cmp);
      end
   endtask
   task automatic chk_halt();
      chk_bit("cpu_clk", 1'h0, cpu);
      chk_bit("mem", 1'h0, mem);
      chk_bit("port_hold", 1'h1, hold);
      chk_bit("xtal", 1'h0, xtal);
      chk_bit("ext", 1'h0, ext);
   endtask
   task automatic chk_snz(logic xs);
      chk_st(SNZ_SNOOZE);
      chk_halt();
      chk_bit("hoco", 1'h1, hoco);
      chk_bit("sub_xt", xs, sxt);
      chk_bit("sub_exs", ~xs, sexs);
      chk_bit("loco", r.loco, loco);
      chk_cmp(r.cmp);
      chk_bit("tau", 1'h0, tau);
      chk_bit("gp", 1'h0, gp);
      chk_bit("rtc", 1'h1, rtc & itmr & adc & pga);
   endtask
   task automatic chk_rst();
      chk_st(SNZ_RUN);
      chk_bit("cpu_mem_hoco", 1'h1, cpu & mem & hoco);
      chk_bit("osc_off", 1'h0, xtal | ext | sxt | sexs | loco | hold);
      chk_cmp(6'h00);
   endtask
   task automatic final_report();
      if (err_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ======================================================
   // a hang counts as a failure
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      final_report();
   end
   // ======================================================
   // main sequence
   initial begin
      {rstn, stop_req, wake, done, it_sel, xt_req, exs_req} = 7'h00;
      {fire_rx, fire_ad, on_hoco, opt, rel, filt, run} = 29'h4000000;
      repeat (5) step();
      chk_rst();
      rstn = 1'h1;
      for (int i = 0; i < 5; i++) begin
         r = rows[i];
         {it_sel, opt, rel, filt, run} = {r.it, r.opt, r.rel, r.filt, r.run};
         {xt_req, exs_req} = {i[0], ~i[0]};
         step();
         stop_req = 1'h1;
         step();
         stop_req = 1'h0;
         chk_st(SNZ_STOP);
         chk_halt();
         // stale requests in stop must not reach the subsystem clocks
         {xt_req, exs_req} = {~i[0], i[0]};
         if (i[0]) fire_ad = 1'h1; else fire_rx = 1'h1;
         step();
         {fire_rx, fire_ad} = 2'h0;
         step();
         chk_snz(i[0]);
         if (i[0]) begin
            done = 1'h1;
            step();
            done = 1'h0;
            chk_st(SNZ_STOP);
         end
         wake = 1'h1;
         step();
         wake = 1'h0;
         chk_st(SNZ_RUN);
         chk_bit("cpu_run", 1'h1, cpu & mem);
      end
      // not on hoco at stop entry: events must be ignored
      on_hoco = 1'h0;
      stop_req = 1'h1;
      step();
      {stop_req, on_hoco, fire_rx} = 3'h3;
      step();
      fire_rx = 1'h0;
      step();
      chk_st(SNZ_STOP);
      // leave stop, re-enter on hoco, then wake and event together
      wake = 1'h1;
      step();
      chk_st(SNZ_RUN);
      {wake, stop_req} = 2'h1;
      step();
      {stop_req, fire_ad} = 2'h1;
      step();
      {fire_ad, wake} = 2'h1;
      step();
      wake = 1'h0;
      chk_st(SNZ_RUN);
      // back to back entry; wake beats done in snooze
      stop_req = 1'h1;
      step();
      {stop_req, fire_rx} = 2'h1;
      step();
      fire_rx = 1'h0;
      step();
      chk_st(SNZ_SNOOZE);
      {wake, done} = 2'h3;
      step();
      {wake, done, stop_req} = 3'h1;
      chk_st(SNZ_RUN);
      step();
      {stop_req, fire_rx} = 2'h1;
      step();
      fire_rx = 1'h0;
      step();
      chk_st(SNZ_SNOOZE);
      // reset in mid snooze, then a request at the first edge after it
      rstn = 1'h0;
      step();
      chk_rst();
      {rstn, stop_req} = 2'h3;
      step();
      stop_req = 1'h0;
      chk_st(SNZ_STOP);
      chk_halt();
      final_report();
   end
endmodule // snooze_mode_clock_gating_bench
`default_nettype wire
